// [verilog/interrupt_priority_and_test.sv]
`include "interrupt_priority_and_test_regs.svh"

// Behaviour
// - Each force bit written to 1 raises one vector, bits 7 to 0 mapping to vectors xE down to x0.
// - Force bits take writes only in special mode with the test write enable bit set.
// - While forcing is active the peripheral lines are cut off and only force bits and resets request.
// - In special mode a test register read shows which block requests have arrived.
// - One test register per group of eight, all at one address, picked by the bank select field.
// - With bank select at its maximum only bits 2:0 are reachable and bits 7:3 read zero.
// - A bank select naming a missing test register ignores writes and reads zero.
// - The promote register reads at any time and takes writes only while the CPU mask bit is 1.
// - The maskable interrupt whose vector low byte matches the promote field wins among maskables.
// - An unimplemented or out-of-range promote value makes the external request vector top.
// - Every reset and interrupt request is arbitrated into one vector by fixed priority, except the promoted maskable.
module interrupt_priority_and_test #(
	parameter int ADDR_W = 10,
	// Banks without a test register read zero and refuse writes
	parameter logic [15:0] BANK_PRESENT = 16'hff00
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic special_mode,
	input wire logic cpu_i_mask,
	input wire logic cpu_x_mask,
	input wire logic [2:0] reset_req,
	input wire logic nonmask_req,
	input wire logic [`MASKABLE_SLOTS-1:0] irq_req,
	output logic exc_valid,
	output logic [15:0] exc_vector
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [15:0] vec_of(input logic [6:0] slot);
		vec_of = {`VEC_PAGE, slot, 1'b0};
	endfunction

	function automatic logic [15:0] page_vec(input logic [7:0] low);
		page_vec = {`VEC_PAGE, low};
	endfunction

	// Highest slot wins among plain maskables; bit 7 of the result flags a hit
	function automatic logic [7:0] top_slot(input logic [`MASKABLE_SLOTS-1:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < `MASKABLE_SLOTS; i++) begin
			if (v[i]) begin
				r = {1'b1, 7'(i)};
			end
		end
		top_slot = r;
	endfunction

	function automatic logic bank_exists(input logic [3:0] bank);
		bank_exists = BANK_PRESENT[bank];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	interrupt_priority_and_test_pkg::bus_state_e bus_state_reg, bus_state_next;
	logic waitrequest_reg, waitrequest_next;
	logic [31:0] readdata_reg, readdata_next;
	logic special_meta_reg;
	logic special_sync_reg;
	logic [4:0] test_ctrl_reg, test_ctrl_next;
	logic [6:0] promote_reg, promote_next;
	logic [7:0] force_reg [16];
	logic [7:0] force_next [16];
	logic exc_valid_reg, exc_valid_next;
	logic [15:0] exc_vector_reg, exc_vector_next;

	logic [7:0] idx;
	logic hit_ctrl, hit_data, hit_status, hit_promote;
	logic [3:0] bank_sel;
	logic test_active;
	logic [127:0] eff_slots;
	logic [7:0] bank_view;
	logic [7:0] bank_mask;
	logic [7:0] read_value;
	logic [`MASKABLE_SLOTS-1:0] maskable;
	logic [7:0] top;
	logic promote_ok;
	logic promote_hit;
	logic irq_first_hit;
	logic write_strobe;

	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;
	assign exc_valid = exc_valid_reg;
	assign exc_vector = exc_vector_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Special mode pin synchroniser

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			special_meta_reg <= 1'b0;
			special_sync_reg <= 1'b0;
		end else begin
			special_meta_reg <= special_mode;
			special_sync_reg <= special_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request view

	assign bank_sel = test_ctrl_reg[`BANK_SEL_MSB:`BANK_SEL_LSB];
	// Forcing needs both the synchronised mode pin and the enable bit
	assign test_active = special_sync_reg & test_ctrl_reg[`TEST_WE_BIT];

	// Peripheral lines are cut off entirely while forcing, so a stray line cannot
	// disturb a priority test
	always_comb begin
		for (int s = 0; s < 128; s++) begin
			if (test_active) begin
				eff_slots[s] = force_reg[s / 8][s % 8];
			end else if (s < `MASKABLE_SLOTS) begin
				eff_slots[s] = irq_req[s];
			end else if (s == 32'(`NONMASK_SLOT)) begin
				eff_slots[s] = nonmask_req;
			end else begin
				eff_slots[s] = 1'b0;
			end
		end
	end

	assign bank_mask = (bank_sel == `BANK_SEL_MAX) ? `LAST_BANK_MASK : 8'hff;
	assign bank_view = eff_slots[{bank_sel, 3'h0} +: 8] & bank_mask;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus

	assign idx = address[ADDR_W-1:2];
	assign hit_ctrl = (idx == `TEST_CTRL_IDX);
	assign hit_data = (idx == `TEST_DATA_IDX);
	assign hit_status = (idx == `STATUS_IDX);
	assign hit_promote = (idx == `PROMOTE_IDX);

	always_comb begin
		read_value = 8'h00;
		if (hit_ctrl) begin
			read_value = {3'h0, test_ctrl_reg};
		end else if (hit_data) begin
			if (special_sync_reg && bank_exists(bank_sel)) begin
				read_value = bank_view;
			end
		end else if (hit_status) begin
			read_value = {5'h00, exc_valid_reg, test_active, special_sync_reg};
		end else if (hit_promote) begin
			read_value = {promote_reg, 1'b0};
		end
	end

	// One wait cycle: read data is captured, then waitrequest drops for one
	// edge at which the write lands and the master samples
	always_comb begin
		bus_state_next = bus_state_reg;
		waitrequest_next = 1'b1;
		readdata_next = readdata_reg;
		case (bus_state_reg)
			interrupt_priority_and_test_pkg::BUS_IDLE: begin
				if (read || write) begin
					bus_state_next = interrupt_priority_and_test_pkg::BUS_ACK;
					waitrequest_next = 1'b0;
					// Taken at the request edge so the word stands through the answer
					readdata_next = read ? {24'h000000, read_value} : 32'h00000000;
				end
			end
			interrupt_priority_and_test_pkg::BUS_ACK: begin
				bus_state_next = interrupt_priority_and_test_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = interrupt_priority_and_test_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_state_reg <= interrupt_priority_and_test_pkg::BUS_IDLE;
			waitrequest_reg <= 1'b1;
			readdata_reg <= 32'h00000000;
		end else begin
			bus_state_reg <= bus_state_next;
			waitrequest_reg <= waitrequest_next;
			readdata_reg <= readdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write strobe

	// Writes land only at the edge where the master sees waitrequest low
	assign write_strobe = (bus_state_reg == interrupt_priority_and_test_pkg::BUS_ACK)
		&& write && byteenable[0];

	////////////////////////////////////////////////////////////////////////////////
	// Test registers

	// Force bits persist until rewritten or reset, so banks are set up one at a time
	always_comb begin
		test_ctrl_next = test_ctrl_reg;
		for (int b = 0; b < 16; b++) begin
			force_next[b] = force_reg[b];
		end
		if (write_strobe && hit_ctrl) begin
			test_ctrl_next = writedata[4:0];
		end
		if (write_strobe && hit_data && test_active) begin
			if (bank_exists(bank_sel)) begin
				force_next[bank_sel] = writedata[7:0] & bank_mask;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			test_ctrl_reg <= `TEST_CTRL_RESET;
			for (int b = 0; b < 16; b++) begin
				force_reg[b] <= 8'h00;
			end
		end else begin
			test_ctrl_reg <= test_ctrl_next;
			for (int b = 0; b < 16; b++) begin
				force_reg[b] <= force_next[b];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority promotion register

	// The mask bit is looked at on the landing edge itself
	always_comb begin
		promote_next = promote_reg;
		if (write_strobe && hit_promote && cpu_i_mask) begin
			promote_next = writedata[`PROMOTE_MSB:`PROMOTE_LSB];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			promote_reg <= `PROMOTE_RESET;
		end else begin
			promote_reg <= promote_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Exception arbitration

	assign maskable = eff_slots[`MASKABLE_SLOTS-1:0];
	assign top = top_slot(maskable);
	assign promote_ok = (promote_reg <= `MASKABLE_TOP) && bank_exists(promote_reg[6:3]);
	assign promote_hit = promote_ok && eff_slots[promote_reg];
	assign irq_first_hit = !promote_ok && maskable[`MASKABLE_TOP];

	// Fixed order: resets, then the non-maskable request, then maskables
	// Promotion reorders maskables only; it never lifts one above a reset
	always_comb begin
		exc_valid_next = 1'b1;
		exc_vector_next = 16'h0000;
		if (reset_req[0]) begin
			exc_vector_next = page_vec(`RESET_VEC0);
		end else if (reset_req[1]) begin
			exc_vector_next = page_vec(`RESET_VEC1);
		end else if (reset_req[2]) begin
			exc_vector_next = page_vec(`RESET_VEC2);
		end else if (eff_slots[`NONMASK_SLOT] && !cpu_x_mask) begin
			exc_vector_next = page_vec(`NONMASK_VEC);
		end else if (!cpu_i_mask && promote_hit) begin
			exc_vector_next = vec_of(promote_reg);
		end else if (!cpu_i_mask && irq_first_hit) begin
			exc_vector_next = vec_of(`MASKABLE_TOP);
		end else if (!cpu_i_mask && top[7]) begin
			exc_vector_next = vec_of(top[6:0]);
		end else begin
			exc_valid_next = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_valid_reg <= 1'b0;
			exc_vector_reg <= 16'h0000;
		end else begin
			exc_valid_reg <= exc_valid_next;
			exc_vector_reg <= exc_vector_next;
		end
	end

endmodule

// [verilog/interrupt_priority_and_test_regs.svh]
`ifndef INTERRUPT_PRIORITY_AND_TEST_REGS_SVH
`define INTERRUPT_PRIORITY_AND_TEST_REGS_SVH

// Register indices; byte address is four times the index
`define TEST_CTRL_IDX 8'h15
`define TEST_DATA_IDX 8'h16
`define STATUS_IDX 8'h17
`define PROMOTE_IDX 8'h1f

// Test control fields
`define TEST_WE_BIT 4
`define BANK_SEL_MSB 3
`define BANK_SEL_LSB 0
`define BANK_SEL_MAX 4'hf
`define LAST_BANK_MASK 8'h07
`define TEST_CTRL_RESET 5'h00

// Priority promotion: field holds vector low byte bits 7 to 1
`define PROMOTE_MSB 7
`define PROMOTE_LSB 1
`define PROMOTE_RESET 7'h79

// Vector slots: slot number is the vector low byte shifted right by one
`define MASKABLE_TOP 7'h79
`define MASKABLE_SLOTS 122
`define NONMASK_SLOT 7'h7a
`define VEC_PAGE 8'hff
`define RESET_VEC0 8'hfe
`define RESET_VEC1 8'hfc
`define RESET_VEC2 8'hfa
`define NONMASK_VEC 8'hf4

`endif

// [verilog/interrupt_priority_and_test_pkg.sv]
package interrupt_priority_and_test_pkg;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_e;

	typedef logic [6:0] slot_t;

endpackage

// [bench/interrupt_priority_and_test_chk.sv]
module interrupt_priority_and_test_chk #(
	parameter int ADDR_W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic special_mode,
	input wire logic cpu_i_mask,
	input wire logic cpu_x_mask,
	input wire logic [2:0] reset_req,
	input wire logic nonmask_req,
	input wire logic exc_valid,
	input wire logic [15:0] exc_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Long enough for the mode synchroniser to have settled low
	sequence quiet;
		(!special_mode)[*4];
	endsequence
	sequence ack_pulse;
		!waitrequest ##1 waitrequest;
	endsequence
	sequence ack_at(idx);
		read && !waitrequest && address[9:2] == idx;
	endsequence
	////////////////////////////////////////////////////////////
	chk_reset_first: assert property (reset_req[0] |=> exc_vector == 16'hfffe)
		else $error("first reset vector wrong");
	chk_reset_second: assert property (reset_req[1:0] == 2'b10 |=> exc_vector == 16'hfffc)
		else $error("second reset vector wrong");
	chk_reset_third: assert property (reset_req == 3'b100 |=> exc_valid && exc_vector == 16'hfffa)
		else $error("third reset vector wrong");
	chk_nonmask_vec: assert property (quiet ##0 (reset_req == 3'h0 && nonmask_req && !cpu_x_mask)
		|=> exc_vector == 16'hfff4) else $error("nonmaskable vector wrong");
	chk_all_masked: assert property (quiet ##0 (reset_req == 3'h0 && cpu_x_mask && cpu_i_mask)
		|=> !exc_valid) else $error("request while all masked");
	chk_ack_once: assert property ($rose(read) || $rose(write) |=> ack_pulse)
		else $error("access not answered in one cycle");
	chk_promote_bit0: assert property (ack_at(8'h1f) |-> readdata[31:8] == 24'h0 && !readdata[0])
		else $error("promote low bit not zero");
	chk_data_plain: assert property (quiet ##0 ack_at(8'h16) |-> readdata == 32'h0)
		else $error("test data visible outside special mode");
endmodule
bind interrupt_priority_and_test interrupt_priority_and_test_chk #(.ADDR_W(ADDR_W)) u_chk (
	.clk(clk), .rst(rst), .address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .special_mode(special_mode), .cpu_i_mask(cpu_i_mask),
	.cpu_x_mask(cpu_x_mask), .reset_req(reset_req), .nonmask_req(nonmask_req),
	.exc_valid(exc_valid), .exc_vector(exc_vector)
);

// [bench/irq_source_model.sv]
module irq_source_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [121:0] pend,
	input wire logic want_mask,
	output logic [121:0] irq_req,
	output logic cpu_i_mask
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines and mask move one edge after the request, as a registered core would
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_req <= '0;
			cpu_i_mask <= 1'b1;
		end else begin
			irq_req <= pend;
			cpu_i_mask <= want_mask;
		end
	end
endmodule

// [bench/interrupt_priority_and_test_bench.sv]
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module interrupt_priority_and_test_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, special_mode = 1'b0;
	logic cpu_x_mask = 1'b1, nonmask_req = 1'b0, want_mask = 1'b1;
	logic exc_valid, waitrequest, cpu_i_mask;
	logic [9:0] address = 10'h0;
	logic [31:0] writedata = 32'h0, readdata;
	logic [2:0] reset_req = 3'h0;
	logic [121:0] pend = '0, irq_req;
	logic [15:0] exc_vector;
	logic [7:0] q;
	int failures = 0, comparisons = 0;
	always #5 clk = ~clk;
	interrupt_priority_and_test u_interrupt_priority_and_test (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest), .special_mode(special_mode),
		.cpu_i_mask(cpu_i_mask), .cpu_x_mask(cpu_x_mask), .reset_req(reset_req),
		.nonmask_req(nonmask_req), .irq_req(irq_req), .exc_valid(exc_valid), .exc_vector(exc_vector));
	irq_source_model u_irq_source_model (.clk(clk), .rst(rst), .pend(pend), .want_mask(want_mask),
		.irq_req(irq_req), .cpu_i_mask(cpu_i_mask));
	////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		read <= ~w;
		write <= w;
		// Only the watchdog ends a wait that never sees the answer
		do begin @(posedge clk); end while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string n);
		bus(1'b0, idx, 8'h00);
		`CHK(n, e, q)
	endtask
	// Model lag plus registered arbiter, with margin
	task automatic vec(input logic [15:0] e);
		repeat (4) @(posedge clk);
		`CHK("exc_vector", e, exc_vector)
	endtask
	////////////////////////////////////////////////////////////
	task automatic s_reset;
		rd(8'h1f, 8'hf2, "promote");
		rd(8'h16, 8'h00, "data_plain");
		rd(8'h17, 8'h00, "status_idle");
		`CHK("exc_valid", 1'b0, exc_valid)
	endtask
	task automatic s_priority;
		for (int i = 0; i < 3; i++) begin
			reset_req <= 3'b111 << i;
			vec(16'hfffe - 16'(2 * i));
		end
		reset_req <= 3'h0;
		nonmask_req <= 1'b1;
		cpu_x_mask <= 1'b0;
		vec(16'hfff4);
		cpu_x_mask <= 1'b1;
	endtask
	task automatic s_promote;
		want_mask <= 1'b0;
		pend <= (122'h1 << 64) | (122'h1 << 112);
		bus(1'b1, 8'h1f, 8'h80);
		rd(8'h1f, 8'hf2, "promote_locked");
		vec(16'hffe0);
		want_mask <= 1'b1;
		bus(1'b1, 8'h1f, 8'h81);
		rd(8'h1f, 8'h80, "promote");
		want_mask <= 1'b0;
		vec(16'hff80);
		want_mask <= 1'b1;
		bus(1'b1, 8'h1f, 8'h20);
		want_mask <= 1'b0;
		pend <= pend | (122'h1 << 16) | (122'h1 << 121);
		vec(16'hfff2);
		want_mask <= 1'b1;
		bus(1'b1, 8'h1f, 8'hfc);
		want_mask <= 1'b0;
		vec(16'hfff2);
		want_mask <= 1'b1;
		pend <= 122'h1 << 64;
	endtask
	task automatic s_test;
		special_mode <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b1, 8'h15, 8'h08);
		bus(1'b1, 8'h16, 8'hff);
		rd(8'h16, 8'h01, "live_bank8");
		bus(1'b1, 8'h15, 8'h18);
		rd(8'h16, 8'h00, "force_after_locked");
		bus(1'b1, 8'h16, 8'h04);
		rd(8'h16, 8'h04, "force_bank8");
		want_mask <= 1'b0;
		vec(16'hff84);
		want_mask <= 1'b1;
		bus(1'b1, 8'h15, 8'h1f);
		bus(1'b1, 8'h16, 8'hff);
		rd(8'h16, 8'h07, "bank_top");
		bus(1'b1, 8'h15, 8'h13);
		bus(1'b1, 8'h16, 8'hff);
		rd(8'h16, 8'h00, "bank_missing");
		bus(1'b1, 8'h15, 8'h18);
		rd(8'h16, 8'h04, "bank8_again");
		rd(8'h17, 8'h03, "status_forcing");
		rd(8'h00, 8'h00, "unmapped");
		special_mode <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b1, 8'h16, 8'h00);
		special_mode <= 1'b1;
		repeat (4) @(posedge clk);
		rd(8'h16, 8'h04, "force_outside_special");
		special_mode <= 1'b0;
	endtask
	task automatic wrap_up;
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		s_reset;
		s_priority;
		s_promote;
		s_test;
		wrap_up;
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		wrap_up;
	end
endmodule
